// [dv/kwu_key_partner.sv]
// key switches and clock generator side of the key wakeup detector
// assumes the bench commands the key levels through keyCmd
module kwu_key_partner (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // key switches and slow clock tick
  input wire logic [3:0] keyCmd,
  output logic [3:0] keyIn,
  output logic slowTick,
  // clock generator
  input wire logic keyWakeupRequest,
  output logic wakeLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tickDiv;
  // slow clock never stops, so the dynamic pull-up keeps its timing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) tickDiv <= 1'b0;
    else tickDiv <= ~tickDiv;
  end
  assign slowTick = tickDiv;
  assign keyIn = keyCmd;
  // detect level fixed at high level, code 001
  assign wakeLevel = (keyWakeupRequest === 1'b1);
endmodule

// [dv/kwu_key_wakeup_unit_tb.sv]
// self-checking bench for the key wakeup detector top
// assumes the partner supplies slow ticks every second clock
module kwu_key_wakeup_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import kwu_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b0, regWr = 1'b0, regRd = 1'b0, rdSeen = 1'b0;
  logic [KWU_AW-1:0] regAddr = '0;
  logic [31:0] regWdata = '0, regRdata, expQ[$], r, e;
  logic [3:0] keyCmd = 4'h0, keyIn, pullupEn;
  logic slowTick, keyWakeupRequest, wakeLevel;
  int error_cnt = 0, n_compared = 0, cyc = 0, on;
  always #20 clk_sys = ~clk_sys;
  kwu_key_wakeup_unit u_kwu_key_wakeup_unit (.clk_sys(clk_sys), .rst(rst),
    .slowTick(slowTick), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .keyIn(keyIn), .pullupEn(pullupEn),
    .keyWakeupRequest(keyWakeupRequest));
  kwu_key_partner u_kwu_key_partner (.clk_sys(clk_sys), .rst(rst), .keyCmd(keyCmd),
    .keyIn(keyIn), .slowTick(slowTick), .keyWakeupRequest(keyWakeupRequest),
    .wakeLevel(wakeLevel));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [KWU_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [KWU_AW-1:0] a, input logic [31:0] x);
    @(posedge clk_sys);
    expQ.push_back(x);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic key(input logic [3:0] k);
    @(posedge clk_sys);
    keyCmd <= k;
    repeat (6) @(posedge clk_sys);
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    cyc++;
    if (rdSeen) chk("regRdata", expQ.pop_front(), regRdata);
    rdSeen <= regRd;
    if (cyc > 60000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    // a rising reset edge, so the asynchronous reset branches really run
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("pullupEn", 32'hF, {28'h0, pullupEn});
    rd(KWU_ADDR_CFG, 32'h0);
    rd(KWU_ADDR_MON, 32'h0);
    rd(KWU_ADDR_CLR, 32'h0);
    rd(4'h2, 32'h0);
    r = lfsr(32'hfc51);
    wr(KWU_ADDR_CFG, r);
    rd(KWU_ADDR_CFG, r & 32'h3C);
    wr(KWU_ADDR_KEY0, 32'h11);
    key(4'h1);
    chk("request", 32'h1, {31'h0, keyWakeupRequest});
    chk("wakeLevel", 32'h1, {31'h0, wakeLevel});
    rd(KWU_ADDR_MON, 32'h1);
    rd(KWU_ADDR_MON, 32'h1);
    key(4'h0);
    rd(KWU_ADDR_MON, 32'h1);
    rd(KWU_ADDR_MON, 32'h0);
    chk("request", 32'h0, {31'h0, keyWakeupRequest});
    // each active-state code against a falling then a rising key
    for (int c = 0; c < 8; c++) begin
      wr(KWU_ADDR_KEY0, 32'h0);
      key(4'h1);
      wr(KWU_ADDR_CLR, 32'hA);
      wr(KWU_ADDR_KEY0, {24'h0, 1'b0, c[2:0], 4'h1});
      key(4'h0);
      e = 32'(8'h17 >> c);
      chk("fallRequest", e & 32'h1, {31'h0, keyWakeupRequest});
      wr(KWU_ADDR_KEY0, 32'h0);
      wr(KWU_ADDR_CLR, 32'hA);
      wr(KWU_ADDR_KEY0, {24'h0, 1'b0, c[2:0], 4'h1});
      key(4'h1);
      e = 32'(8'h1B >> c);
      chk("riseRequest", e & 32'h1, {31'h0, keyWakeupRequest});
    end
    wr(KWU_ADDR_KEY0, 32'h31);
    wr(KWU_ADDR_CLR, 32'hA);
    key(4'h0);
    key(4'h1);
    rd(KWU_ADDR_MON, 32'h1);
    rd(KWU_ADDR_MON, 32'h0);
    wr(KWU_ADDR_KEY0 + 5'h04, 32'h31);
    key(4'h0);
    key(4'h3);
    wr(KWU_ADDR_CLR, 32'h5);
    chk("request", 32'h1, {31'h0, keyWakeupRequest});
    wr(KWU_ADDR_CLR, 32'hA);
    chk("request", 32'h0, {31'h0, keyWakeupRequest});
    rd(KWU_ADDR_MON, 32'h0);
    // dynamic pull-up: on time over 4096 clocks of whole repeat windows, fields crossed
    wr(KWU_ADDR_KEY0, 32'h91);
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      wr(KWU_ADDR_CFG, (r & 32'hFFFF_FFC0) | (i << 4) | ((3 - i) << 2));
      wr(KWU_ADDR_CLR, 32'hA);
      repeat (4200) @(posedge clk_sys);
      on = 0;
      repeat (4096) begin
        @(posedge clk_sys);
        on += (pullupEn[0] === 1'b1);
      end
      chk("pullupOn", 32'd256 >> (2 * i), on);
      chk("staticPullup", 32'hE, {28'h0, pullupEn & 4'hE});
      chk("dynRequest", 32'h1, {31'h0, keyWakeupRequest});
    end
    repeat (3) @(posedge clk_sys);
    give_verdict();
  end
endmodule

// [pkg/kwu_pkg.sv]
// constants, register map and types shared by the key wakeup detector
// assumes a single system clock; the slow clock arrives as a synchronous tick
// Function
// RULE1 - repeat cycle select picks 256, 512, 1024 or 2048 slow clock periods
// RULE2 - pull-up driven only for first 2, 4, 8 or 16 slow periods of cycle
// RULE3 - writing 1010 to clear pattern field clears all pending key flags
// RULE4 - enabled key showing its active condition sets its flag bit
// RULE5 - reading monitor register clears the flag bits that read as one
// RULE6 - level-mode key still active keeps its flag set after a read; in dynamic mode a read between sample strobes clears it until the next one
// RULE7 - four key inputs, each with own enable and active state
// RULE8 - combined result goes to clock generator as active-high level
// RULE9 - clock generator detect level must be set to high level code 001
// RULE10 - clock generator stop release select chooses wakeup or normal interrupt
// RULE11 - a clear removes all pending key requests together
// RULE12 - static pull-up stays on regardless of the key interrupt enable
// RULE13 - slow clock must keep running while dynamic pull-up is used
// RULE14 - software waits one pull-up-on period after changing dynamic settings
// RULE15 - dynamic mode samples keys one slow period before pull-up-on ends
// RULE16 - active state 000 low, 001 high, 010 fall, 011 rise, 100 both
// RULE17 - pull-up mode bit 0 static, 1 dynamic
// RULE18 - reserved active state codes never set the key flag
// RULE19 - combined request is the OR of the four key flags
package kwu_pkg;
  localparam int KWU_NKEYS = 4;
  // five address bits so key controls at 0x0C..0x18 do not alias the other registers
  localparam int KWU_AW = 5;
  localparam logic [KWU_AW-1:0] KWU_ADDR_CFG = 5'h00;
  localparam logic [KWU_AW-1:0] KWU_ADDR_CLR = 5'h04;
  localparam logic [KWU_AW-1:0] KWU_ADDR_MON = 5'h08;
  localparam logic [KWU_AW-1:0] KWU_ADDR_KEY0 = 5'h0C;
  localparam int KWU_T2_LSB = 4;
  localparam int KWU_T1_LSB = 2;
  localparam int KWU_KEN_BIT = 0;
  localparam int KWU_KST_LSB = 4;
  localparam int KWU_DPE_BIT = 7;
  localparam logic [3:0] KWU_CLR_MAGIC = 4'hA;
  localparam int KWU_T2_BASE_LOG = 8;
  localparam int KWU_T1_BASE_LOG = 1;
  localparam int KWU_CNT_W = 11;
  localparam logic [31:0] KWU_RESET_VAL = 32'h00000000;
  typedef enum logic [2:0] {
    KWU_ACT_LOW  = 3'b000,
    KWU_ACT_HIGH = 3'b001,
    KWU_ACT_FALL = 3'b010,
    KWU_ACT_RISE = 3'b011,
    KWU_ACT_BOTH = 3'b100
  } kwu_act_t;
endpackage

// [pkg/kwu_pu_if.sv]
// pull-up timing carrier between the detector top and its timer
// assumes both ends share clk_sys
interface kwu_pu_if;
  logic [1:0] repeatSel;
  logic [1:0] onSel;
  logic puOn;
  logic sampleStrobe;
  modport timer (input repeatSel, input onSel, output puOn, output sampleStrobe);
  modport user (output repeatSel, output onSel, input puOn, input sampleStrobe);
endinterface

// [rtl/kwu_key_detect.sv]
// one key channel: active state decode and flag hold
// assumes key input synchronous to clk_sys
module kwu_key_detect
  import kwu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // configuration and sample strobe
  input wire logic enable,
  input wire logic [2:0] actState,
  input wire logic dynMode,
  input wire logic sampleStrobe,
  // key and control
  input wire logic keyIn,
  input wire logic readClr,
  input wire logic clrAll,
  output logic flag,
  output logic levelActive
);
  logic prev_reg, prev_next, flag_reg, flag_next, take, hit;

  always_comb begin
    take = dynMode ? sampleStrobe : 1'b1; // RULE15
    prev_next = take ? keyIn : prev_reg;
    hit = 1'b0;
    levelActive = 1'b0;
    case (actState) // RULE16
      KWU_ACT_LOW: levelActive = !keyIn;
      KWU_ACT_HIGH: levelActive = keyIn;
      KWU_ACT_FALL: hit = prev_reg && !keyIn;
      KWU_ACT_RISE: hit = !prev_reg && keyIn;
      KWU_ACT_BOTH: hit = prev_reg != keyIn;
      default: hit = 1'b0; // RULE18
    endcase
    hit = enable && take && (hit || levelActive); // RULE4
    flag_next = flag_reg;
    if (readClr || clrAll) flag_next = 1'b0; // RULE5 RULE11
    if (hit) flag_next = 1'b1; // RULE6
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_reg <= 1'b1;
      flag_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      flag_reg <= flag_next;
    end
  end
  assign flag = flag_reg;

  chk_reserved_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (actState > KWU_ACT_BOTH && !flag_reg) |=> !flag_reg) else $error("reserved code set flag"); // RULE18
  chk_clear_all: assert property (@(posedge clk_sys) disable iff (rst)
    (clrAll && !hit) |=> !flag_reg) else $error("clear missed"); // RULE3
  chk_dyn_sample: assert property (@(posedge clk_sys) disable iff (rst) // RULE15
    (dynMode && !sampleStrobe && !flag_reg) |=> !flag_reg) else $error("dynamic flag off sample");
endmodule

// [rtl/kwu_key_wakeup_unit.sv]
// key wakeup detector top: registers, four key channels, pull-up drive
// assumes inputs synchronous to clk_sys, slowTick one pulse per slow clock period
module kwu_key_wakeup_unit
  import kwu_pkg::*;
#(
  parameter int NKEYS = KWU_NKEYS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic slowTick,
  // register port
  input wire logic [KWU_AW-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // keys and pull-ups
  input wire logic [NKEYS-1:0] keyIn,
  output logic [NKEYS-1:0] pullupEn,
  // clock generator
  output logic keyWakeupRequest
);
  logic [31:0] cfg_reg, cfg_next;
  logic [7:0] keyCfg_reg [NKEYS], keyCfg_next [NKEYS];
  logic [31:0] rdata_reg, rdata_next;
  logic [NKEYS-1:0] pull_reg, pull_next, flags, lvl, rdClr, lvlEn;
  logic req_reg, req_next, clrAll;
  kwu_pu_if pu();

  function automatic logic isKeyAddr(input logic [KWU_AW-1:0] a, input int k);
    return a == KWU_AW'(KWU_ADDR_KEY0 + KWU_AW'(4 * k));
  endfunction

  assign pu.repeatSel = cfg_reg[KWU_T2_LSB +: 2];
  assign pu.onSel = cfg_reg[KWU_T1_LSB +: 2];

  kwu_pullup_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .slowTick(slowTick),
    .pu(pu)
  );

  always_comb begin
    clrAll = regWr && regAddr == KWU_ADDR_CLR && regWdata[3:0] == KWU_CLR_MAGIC; // RULE3
  end

  genvar g;
  generate
    for (g = 0; g < NKEYS; g++) begin : gKey // RULE7
      assign rdClr[g] = regRd && regAddr == KWU_ADDR_MON && flags[g]; // RULE5
      kwu_key_detect u_key (
        .clk_sys(clk_sys),
        .rst(rst),
        .enable(keyCfg_reg[g][KWU_KEN_BIT]),
        .actState(keyCfg_reg[g][KWU_KST_LSB +: 3]),
        .dynMode(keyCfg_reg[g][KWU_DPE_BIT]),
        .sampleStrobe(pu.sampleStrobe),
        .keyIn(keyIn[g]),
        .readClr(rdClr[g]),
        .clrAll(clrAll), // RULE11
        .flag(flags[g]),
        .levelActive(lvl[g])
      );
      // static mode keeps the pull-up on regardless of enable
      assign pull_next[g] = keyCfg_reg[g][KWU_DPE_BIT] ? pu.puOn : 1'b1; // RULE12 RULE17
      assign lvlEn[g] = lvl[g] && keyCfg_reg[g][KWU_KEN_BIT];
    end
  endgenerate

  always_comb begin
    cfg_next = cfg_reg;
    for (int k = 0; k < NKEYS; k++) keyCfg_next[k] = keyCfg_reg[k];
    rdata_next = '0;
    if (regWr) begin
      if (regAddr == KWU_ADDR_CFG) begin
        cfg_next = regWdata & 32'h0000003C;
      end else begin
        for (int k = 0; k < NKEYS; k++) begin
          if (isKeyAddr(regAddr, k)) keyCfg_next[k] = regWdata[7:0] & 8'hF1;
        end
      end
    end
    if (regRd) begin
      if (regAddr == KWU_ADDR_CFG) begin
        rdata_next = cfg_reg;
      end else if (regAddr == KWU_ADDR_MON) begin
        rdata_next = 32'(flags);
      end else begin
        for (int k = 0; k < NKEYS; k++) begin
          if (isKeyAddr(regAddr, k)) rdata_next = 32'(keyCfg_reg[k]);
        end
      end
    end
    req_next = |flags; // RULE19 RULE8
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg <= KWU_RESET_VAL;
      for (int k = 0; k < NKEYS; k++) keyCfg_reg[k] <= 8'h00;
      rdata_reg <= KWU_RESET_VAL;
      pull_reg <= '0;
      req_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      for (int k = 0; k < NKEYS; k++) keyCfg_reg[k] <= keyCfg_next[k];
      rdata_reg <= rdata_next;
      pull_reg <= pull_next;
      req_reg <= req_next;
    end
  end
  assign regRdata = rdata_reg;
  assign pullupEn = pull_reg;
  assign keyWakeupRequest = req_reg;

  chk_req_follows: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 keyWakeupRequest == $past(|flags)) else $error("request not OR of flags"); // RULE19
  chk_static_pull: assert property (@(posedge clk_sys) disable iff (rst)
    !keyCfg_reg[0][KWU_DPE_BIT] ##1 !keyCfg_reg[0][KWU_DPE_BIT] |-> pullupEn[0])
    else $error("static pull-up dropped"); // RULE12
  chk_rd_mon: assert property (@(posedge clk_sys) disable iff (rst)
    (regRd && regAddr == KWU_ADDR_MON) |=> regRdata[3:0] == $past(flags))
    else $error("monitor read wrong"); // RULE5
  chk_level_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (rdClr[0] && lvl[0] && keyCfg_reg[0][KWU_KEN_BIT] && !keyCfg_reg[0][KWU_DPE_BIT])
    |=> flags[0]) else $error("level flag cleared"); // RULE6
  chk_magic_clear: assert property (@(posedge clk_sys) disable iff (rst)
    // an edge or level hit in the clear cycle wins, so only quiet clears are checked
    (clrAll && lvlEn == '0 && $stable(keyIn) && !pu.sampleStrobe) |=> ##1 !keyWakeupRequest)
    else $error("clear-all failed"); // RULE11
  cov_wake: cover property (@(posedge clk_sys) $rose(keyWakeupRequest));
  cov_clear: cover property (@(posedge clk_sys) clrAll && |flags);
  cov_dyn: cover property (@(posedge clk_sys) keyCfg_reg[0][KWU_DPE_BIT] && $fell(pullupEn[0]));
endmodule

// [rtl/kwu_pullup_timer.sv]
// dynamic pull-up timer running on slow clock ticks
// assumes slowTick is a one-cycle pulse per slow clock period
module kwu_pullup_timer
  import kwu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // slow clock tick
  input wire logic slowTick,
  // timing carrier
  kwu_pu_if.timer pu
);
  logic [KWU_CNT_W-1:0] cnt_reg, cnt_next;
  logic [KWU_CNT_W-1:0] cycleLast, onLen;
  logic onNow;

  always_comb begin
    cycleLast = KWU_CNT_W'((32'd1 << (KWU_T2_BASE_LOG + int'(pu.repeatSel))) - 32'd1); // RULE1
    onLen = KWU_CNT_W'(32'd1 << (KWU_T1_BASE_LOG + int'(pu.onSel))); // RULE2
    cnt_next = cnt_reg;
    if (cnt_reg > cycleLast) begin
      // a shorter cycle chosen mid-count restarts at once, not at the next tick
      cnt_next = '0; // RULE1
    end else if (slowTick) begin
      cnt_next = (cnt_reg == cycleLast) ? '0 : cnt_reg + 1'b1; // RULE1
    end
    onNow = (cnt_reg < onLen); // RULE2
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      pu.puOn <= 1'b0;
      pu.sampleStrobe <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pu.puOn <= onNow;
      // sample at the tick that starts the last on period
      pu.sampleStrobe <= slowTick && (cnt_reg == onLen - 2'd2); // RULE15
    end
  end

  chk_pullup_off_late: assert property (@(posedge clk_sys) disable iff (rst)
    (cnt_reg > onLen) |=> !pu.puOn) else $error("pull-up on outside on period"); // RULE2
  chk_cycle_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    cnt_reg <= cycleLast || $changed(pu.repeatSel)) else $error("counter past cycle"); // RULE1
  cov_sample: cover property (@(posedge clk_sys) pu.sampleStrobe);
endmodule
